// File: core/mac_fc_cfg.svh
`ifndef MAC_FC_CFG_SVH
`define MAC_FC_CFG_SVH
// config vector layout
`define VEC_W 368
`define BASE_W 80
`define LEG_REF_LO 352
`define PRIO_REF_LO 112
`define PRIO_QNT_LO 96
`define PRIO_STEP 32
`define PRIO_EN_LO 88
`define AUTO_XON 81
`define PFC_ON 80
`define SA_LO 32
`define MAXLEN_LO 16
`define MAX_EN 14
`define SPEED_LO 12
`define FC_EN 5
`define JUMBO_EN 4
`define VLAN_EN 2
`define TX_ON 1
`define TX_RST 0
`define LEGACY_CH 8
`define SPEED_10M 2'h0
`define SPEED_100M 2'h1
// frame lengths
`define LEGAL_LEN 16'h05EE
`define VLAN_LEN 16'h05F2
`define NO_LIMIT 16'hFFFF
// control frame content
`define PREAMBLE 8'h55
`define SFD_BYTE 8'hD5
`define CTRL_DA 48'h010000C28001
`define ETHTYPE 16'h8808
`define OP_PAUSE 16'h0001
`define OP_PFC 16'h0101
`define CRC_POLY 32'hEDB88320
`define CRC_INIT 32'hFFFFFFFF
// byte positions in a control frame
`define IDX_SFD 7'h07
`define IDX_DA 7'h08
`define IDX_SA 7'h0E
`define IDX_TYPE 7'h14
`define IDX_OP 7'h16
`define IDX_PAY 7'h18
`define IDX_PFCQ 7'h1A
`define IDX_PFCEND 7'h2A
`define IDX_FCS 7'h44
`define IDX_LAST 7'h47
`define FRAME_LEN 72
// timing
`define CLK_NS 20
`define QUANTA_NS_1G 512
`define QUANTA_NS_100M 5120
`define QUANTA_NS_10M 51200
`define MDIO_IDLE 1'h1
`endif

// File: core/mac_fc_pkg.sv
package mac_fc_pkg;
	typedef enum logic {FC_IDLE, FC_SEND} fc_state_e;
	typedef logic [15:0] quanta_t;
	typedef logic [6:0] byte_idx_t;
endpackage : mac_fc_pkg

// File: core/mac_tx_flow_ctrl.sv
// Operation
// - config changes apply only between frames; reset bit acts at once
// - vector bits above 79 exist only when priority flow control is built
// - held pause request sends pause, resent when quanta count hits legacy refresh
// - auto xon: drop after more than one cycle high sends zero-quanta frame
// - per-priority refresh value retriggers a frame while that priority stays high
// - each enabled asserted priority puts its own quanta into the frame
// - per-priority enable bit gates that priority's valid input
// - vector address field is the source address of every control frame
// - bit 0 of the address field is the address lsb, sent first
// - lowest address byte goes first on the wire, then higher bytes
// - max frame size field limits transmit length when max mode on, jumbo off
// - management clock divided from the system clock by configured value
// - management enable low drives the data output, high releases the bus
// - rgmii in-band link, speed, duplex reported; transmit clock forwarded
// - pause request sends a frame only when flow control enable is set
// - max frame enable allows over-length frames up to the configured size
`timescale 1ns/10ps
`include "mac_fc_cfg.svh"
module mac_tx_flow_ctrl
	import mac_fc_pkg::*;
#(
	parameter bit PFC_EN = 1'b1
) (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // sync reset, low
	input wire logic [`VEC_W-1:0] tx_config_vector, // async config
	input wire logic client_busy, // user frame in flight
	input wire logic pause_req, // legacy pause request
	input wire logic [15:0] pause_quanta, // legacy pause value
	input wire logic [7:0] priority_flow_valid_n, // per-priority request
	input wire logic [3:0] rgmii_rxd, // rgmii receive data
	input wire logic rgmii_rx_ctl, // rgmii receive control
	input wire logic [7:0] mdc_div, // mdc half period minus one
	input wire logic mdio_enable, // run mdc
	input wire logic mdio_out_data, // management data out
	input wire logic mdio_out_drive, // management drive
	input wire logic mdio_i, // management pin in
	output logic mdio_in_data, // synced management in
	output logic mdc, // management clock
	output logic mdio_o, // management pin out
	output logic mdio_t, // management enable, low drives
	output logic [7:0] gmii_txd, // control frame byte
	output logic gmii_tx_en, // control frame valid
	output logic gmii_tx_er, // always low
	output logic fc_busy, // control frame in flight
	output logic tx_reset, // transmitter reset
	output logic [15:0] tx_max_len, // transmit size limit
	output logic rgmii_txc, // forwarded transmit clock
	output logic inband_link_status, // in-band link up
	output logic [1:0] inband_clock_speed, // in-band speed
	output logic inband_duplex_status // in-band full duplex
);
	localparam logic [11:0] Q1G_CYC = 12'(`QUANTA_NS_1G / `CLK_NS - 1);
	localparam logic [11:0] Q100_CYC = 12'(`QUANTA_NS_100M / `CLK_NS - 1);
	localparam logic [11:0] Q10_CYC = 12'(`QUANTA_NS_10M / `CLK_NS - 1);
	localparam logic [47:0] DA_W = `CTRL_DA;
	localparam logic [15:0] TYPE_W = `ETHTYPE;

	logic [`VEC_W-1:0] vec_in;
	logic [`VEC_W-1:0] cfg_s1;
	logic [`VEC_W-1:0] cfg_s2;
	logic [`VEC_W-1:0] cfg;
	fc_state_e state;
	byte_idx_t idx;
	logic [31:0] crc;
	logic [7:0] frame_byte;
	logic [11:0] tick_cnt;
	logic [11:0] tick_max;
	logic tick;
	logic is_pfc;
	logic [7:0] cls_mask;
	logic [8:0] ch_req;
	logic [8:0] ch_en;
	logic [8:0] ch_act;
	logic [8:0] ch_prev;
	logic [8:0] ch_run;
	logic [8:0] pend_on;
	logic [8:0] pend_off;
	logic [8:0] refresh_hit;
	logic [8:0] take_mask;
	quanta_t ch_ref [0:8];
	quanta_t ch_qnt [0:8];
	quanta_t qcnt [0:8];
	quanta_t snap [0:8];
	logic leg_pend;
	logic pfc_pend;
	logic start;
	logic [4:0] rx_s1;
	logic [4:0] rx_s2;

	// upper vector tied off when priority support is not built
	generate
		if (PFC_EN) begin : g_full
			assign vec_in = tx_config_vector;
		end else begin : g_base
			assign vec_in = {{(`VEC_W - `BASE_W){1'b0}},
				tx_config_vector[`BASE_W-1:0]};
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cfg_s1 <= '0;
			cfg_s2 <= '0;
		end else begin
			cfg_s1 <= vec_in;
			cfg_s2 <= cfg_s1;
		end
	end

	// applied copy only moves between frames
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			cfg <= '0;
		else if (state == FC_IDLE && !client_busy && !start)
			cfg <= cfg_s2;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			tx_reset <= 1'h0;
		else
			tx_reset <= cfg_s2[`TX_RST];
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			tx_max_len <= `LEGAL_LEN;
		else if (cfg[`JUMBO_EN])
			tx_max_len <= `NO_LIMIT;
		else if (cfg[`MAX_EN])
			tx_max_len <= cfg[`MAXLEN_LO +: 16];
		else if (cfg[`VLAN_EN])
			tx_max_len <= `VLAN_LEN;
		else
			tx_max_len <= `LEGAL_LEN;
	end

	// one pause quantum of time at the current speed
	always_comb begin
		case (cfg[`SPEED_LO +: 2])
			`SPEED_10M: tick_max = Q10_CYC;
			`SPEED_100M: tick_max = Q100_CYC;
			default: tick_max = Q1G_CYC;
		endcase
	end
	assign tick = (tick_cnt >= tick_max);

	always_ff @(posedge sys_clk) begin
		if (!rstn || tick)
			tick_cnt <= 12'h000;
		else
			tick_cnt <= tick_cnt + 12'h001;
	end

	genvar c;
	generate
		for (c = 0; c <= `LEGACY_CH; c++) begin : g_ch
			if (c == `LEGACY_CH) begin : g_leg
				assign ch_req[c] = pause_req;
				assign ch_en[c] = cfg[`FC_EN];
				assign ch_ref[c] = cfg[`LEG_REF_LO +: 16];
				assign ch_qnt[c] = pause_quanta;
			end else begin : g_prio
				assign ch_req[c] = priority_flow_valid_n[c];
				assign ch_en[c] = cfg[`PFC_ON] & cfg[`PRIO_EN_LO + c];
				assign ch_ref[c] = cfg[`PRIO_REF_LO + c * `PRIO_STEP +: 16];
				assign ch_qnt[c] = cfg[`PRIO_QNT_LO + c * `PRIO_STEP +: 16];
			end
			assign ch_act[c] = ch_req[c] & ch_en[c];
			assign refresh_hit[c] = ch_act[c] & ch_prev[c] & (ch_ref[c] != 16'h0000)
				& (qcnt[c] >= ch_ref[c]);

			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					ch_prev[c] <= 1'h0;
					ch_run[c] <= 1'h0;
				end else begin
					ch_prev[c] <= ch_act[c];
					ch_run[c] <= ch_act[c] & ch_prev[c];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rstn || take_mask[c] || !ch_act[c] || refresh_hit[c])
					qcnt[c] <= 16'h0000;
				else if (tick && qcnt[c] != 16'hFFFF)
					qcnt[c] <= qcnt[c] + 16'h0001;
			end

			// a new request wins over the clear by a frame start
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					pend_on[c] <= 1'h0;
					pend_off[c] <= 1'h0;
				end else begin
					pend_on[c] <= (ch_act[c] & ~ch_prev[c]) | refresh_hit[c]
						| (pend_on[c] & ~take_mask[c]);
					pend_off[c] <= (~ch_act[c] & ch_prev[c] & ch_run[c] & cfg[`AUTO_XON])
						| (pend_off[c] & ~take_mask[c]);
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rstn)
					snap[c] <= 16'h0000;
				else if (start)
					snap[c] <= pend_on[c] ? ch_qnt[c] : 16'h0000;
			end

			refresh_trig_a: assert property (@(posedge sys_clk) disable iff (!rstn)
				refresh_hit[c] |=> pend_on[c] && qcnt[c] == 16'h0000)
				else $error("refresh did not raise a frame request");
		end
	endgenerate

	assign leg_pend = pend_on[`LEGACY_CH] | pend_off[`LEGACY_CH];
	assign pfc_pend = |(pend_on[7:0] | pend_off[7:0]);
	assign start = (state == FC_IDLE) && !client_busy && cfg[`TX_ON] && !cfg[`TX_RST]
		&& (leg_pend || pfc_pend);

	// legacy frames go first; a priority frame takes every pending class
	always_comb begin
		take_mask = 9'h000;
		if (start && leg_pend)
			take_mask = 9'h100;
		else if (start)
			take_mask = {1'h0, pend_on[7:0] | pend_off[7:0]};
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			is_pfc <= 1'h0;
			cls_mask <= 8'h00;
		end else if (start) begin
			is_pfc <= !leg_pend;
			cls_mask <= take_mask[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= FC_IDLE;
			idx <= 7'h00;
		end else begin
			case (state)
				FC_IDLE: begin
					idx <= 7'h00;
					if (start)
						state <= FC_SEND;
				end
				FC_SEND: begin
					idx <= idx + 7'h01;
					if (idx == `IDX_LAST)
						state <= FC_IDLE;
				end
				default: state <= FC_IDLE;
			endcase
		end
	end
	assign fc_busy = (state == FC_SEND);

	function automatic logic [31:0] crc_step(input logic [31:0] cin, input logic [7:0] d);
		logic [31:0] r;
		r = cin;
		for (int b = 0; b < 8; b++) begin
			if (r[0] ^ d[b])
				r = (r >> 1) ^ `CRC_POLY;
			else
				r = r >> 1;
		end
		return r;
	endfunction : crc_step

	// byte at position idx of the control frame
	always_comb begin
		logic [6:0] off;
		logic [15:0] word;
		off = 7'h00;
		word = 16'h0000;
		frame_byte = 8'h00;
		if (idx < `IDX_SFD) begin
			frame_byte = `PREAMBLE;
		end else if (idx == `IDX_SFD) begin
			frame_byte = `SFD_BYTE;
		end else if (idx < `IDX_SA) begin
			off = idx - `IDX_DA;
			frame_byte = DA_W[{off[2:0], 3'h0} +: 8];
		end else if (idx < `IDX_TYPE) begin
			off = idx - `IDX_SA;
			frame_byte = cfg[`SA_LO + {off[2:0], 3'h0} +: 8];
		end else if (idx < `IDX_FCS) begin
			if (idx < `IDX_OP)
				word = TYPE_W;
			else if (idx < `IDX_PAY)
				word = is_pfc ? `OP_PFC : `OP_PAUSE;
			else if (idx < `IDX_PFCQ)
				word = is_pfc ? {8'h00, cls_mask} : snap[`LEGACY_CH];
			else if (is_pfc && idx < `IDX_PFCEND) begin
				off = idx - `IDX_PFCQ;
				word = snap[off[3:1]];
			end
			frame_byte = idx[0] ? word[7:0] : word[15:8];
		end else begin
			off = idx - `IDX_FCS;
			frame_byte = ~crc[{off[1:0], 3'h0} +: 8];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn || start)
			crc <= `CRC_INIT;
		else if (state == FC_SEND && idx >= `IDX_DA && idx < `IDX_FCS)
			crc <= crc_step(crc, frame_byte);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			gmii_txd <= 8'h00;
			gmii_tx_en <= 1'h0;
			gmii_tx_er <= 1'h0;
		end else begin
			gmii_txd <= (state == FC_SEND) ? frame_byte : 8'h00;
			gmii_tx_en <= (state == FC_SEND);
			gmii_tx_er <= 1'h0;
		end
	end

	// in-band status is only sent between received frames
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rx_s1 <= 5'h00;
			rx_s2 <= 5'h00;
		end else begin
			rx_s1 <= {rgmii_rx_ctl, rgmii_rxd};
			rx_s2 <= rx_s1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			inband_link_status <= 1'h0;
			inband_clock_speed <= 2'h0;
			inband_duplex_status <= 1'h0;
		end else if (!rx_s2[4]) begin
			inband_link_status <= rx_s2[0];
			inband_clock_speed <= rx_s2[2:1];
			inband_duplex_status <= rx_s2[3];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			rgmii_txc <= 1'h0;
		else
			rgmii_txc <= ~rgmii_txc;
	end

	mdio_pins u_mdio (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.mdc_div(mdc_div),
		.mdio_enable(mdio_enable),
		.mdio_out_data(mdio_out_data),
		.mdio_out_drive(mdio_out_drive),
		.mdio_i(mdio_i),
		.mdio_in_data(mdio_in_data),
		.mdc(mdc),
		.mdio_o(mdio_o),
		.mdio_t(mdio_t)
	);

	cfg_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(fc_busy || client_busy) |=> $stable(cfg))
		else $error("config changed during a frame");
	reset_now_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(cfg_s2[`TX_RST]) |=> tx_reset)
		else $error("reset bit not applied at once");
	fc_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		($rose(pause_req) && !cfg[`FC_EN] && !pend_on[`LEGACY_CH]) |=> !pend_on[`LEGACY_CH])
		else $error("pause request honoured while disabled");
	prio_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(start && !leg_pend) |-> (take_mask[7:0] & ~(pend_on[7:0] | pend_off[7:0])) == 8'h00
		&& (pend_on[7:0] & ~ch_en[7:0] & ~ch_prev[7:0]) == 8'h00)
		else $error("disabled priority in frame");
	auto_xon_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!ch_act[`LEGACY_CH] && ch_prev[`LEGACY_CH] && ch_run[`LEGACY_CH] && cfg[`AUTO_XON])
		|=> pend_off[`LEGACY_CH])
		else $error("auto xon not raised");
	sa_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(fc_busy && idx == `IDX_SA) |=> gmii_txd == cfg[`SA_LO +: 8])
		else $error("first source byte wrong");
	sa_last_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(fc_busy && idx == `IDX_TYPE - 7'h01) |=> gmii_txd == cfg[`SA_LO + 40 +: 8])
		else $error("last source byte wrong");
	pfc_quanta_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(fc_busy && is_pfc && idx == `IDX_PFCQ) |=> gmii_txd == snap[0][15:8]
		##1 gmii_txd == snap[0][7:0])
		else $error("priority quanta misplaced");
	frame_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(gmii_tx_en) |-> ##71 gmii_tx_en ##1 !gmii_tx_en)
		else $error("control frame length wrong");
	max_len_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(cfg[`MAX_EN] && !cfg[`JUMBO_EN]) |=> tx_max_len == $past(cfg[`MAXLEN_LO +: 16]))
		else $error("max frame limit not applied");
endmodule : mac_tx_flow_ctrl

// File: core/mdio_pins.sv
`timescale 1ns/10ps
`include "mac_fc_cfg.svh"
module mdio_pins (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // sync reset, low
	input wire logic [7:0] mdc_div, // mdc half period minus one
	input wire logic mdio_enable, // run mdc
	input wire logic mdio_out_data, // value to drive
	input wire logic mdio_out_drive, // drive request
	input wire logic mdio_i, // pin input
	output logic mdio_in_data, // synced pin input
	output logic mdc, // management clock
	output logic mdio_o, // pin output value
	output logic mdio_t // pin enable, low drives
);
	logic [7:0] div_cnt;
	logic in_s1;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			div_cnt <= 8'h00;
			mdc <= 1'h0;
		end else if (!mdio_enable) begin
			div_cnt <= 8'h00;
			mdc <= 1'h0;
		end else if (div_cnt == mdc_div) begin
			div_cnt <= 8'h00;
			mdc <= ~mdc;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mdio_o <= 1'h0;
			mdio_t <= 1'h1;
		end else begin
			mdio_o <= mdio_out_data;
			mdio_t <= ~mdio_out_drive;
		end
	end

	// idle high when the pin is left tied
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			in_s1 <= `MDIO_IDLE;
			mdio_in_data <= `MDIO_IDLE;
		end else begin
			in_s1 <= mdio_i;
			mdio_in_data <= in_s1;
		end
	end

	mdio_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		mdio_out_drive |=> !mdio_t && mdio_o == $past(mdio_out_data))
		else $error("mdio not driven after drive request");
	mdc_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mdio_enable && div_cnt != mdc_div) |=> $stable(mdc))
		else $error("mdc toggled before divider count");
endmodule : mdio_pins

// File: verification/phy_model.sv
`timescale 1ns/10ps
module phy_model (
	input wire logic sys_clk, // system clock
	input wire logic [7:0] gmii_txd, // byte from mac
	input wire logic gmii_tx_en, // byte valid
	input wire logic mdio_o, // mac data
	input wire logic mdio_t, // mac enable, low drives
	input wire logic phy_drive, // phy drives the pin
	input wire logic phy_bit, // phy data
	input wire logic [3:0] status, // in-band status nibble
	input wire logic rx_busy, // phy receiving a frame
	output logic mdio_i, // resolved pin level
	output logic [3:0] rgmii_rxd, // receive data
	output logic rgmii_rx_ctl // receive control
);
	logic [7:0] fr [0:71];
	int idx = 0;
	int len = 0;
	int frames = 0;
	// shared pin with pull-up, high when nobody drives
	assign mdio_i = (mdio_t | mdio_o) & (~phy_drive | phy_bit);
	// in-band status only while no frame is received
	assign rgmii_rx_ctl = rx_busy;
	assign rgmii_rxd = status;
	// capture on the system clock the testbench supplies
	always @(posedge sys_clk) begin
		if (gmii_tx_en) begin
			if (idx < 72) fr[idx] <= gmii_txd;
			idx <= idx + 1;
		end else if (idx != 0) begin
			len <= idx;
			idx <= 0;
			frames <= frames + 1;
		end
	end
endmodule : phy_model

// File: verification/testbench.sv
`timescale 1ns/10ps
`include "mac_fc_cfg.svh"
module testbench;
	logic sys_clk = 0, rstn = 0, client_busy = 0, pause_req = 0, mdio_enable = 0;
	logic mdio_out_data = 0, mdio_out_drive = 0, phy_drive = 0, phy_bit = 0, rx_busy = 0;
	logic [`VEC_W-1:0] cfg = '0;
	logic [15:0] pause_quanta = 16'h0000, tx_max_len;
	logic [7:0] pfv = 8'h00, mdc_div = 8'h03, gmii_txd;
	logic [3:0] status = 4'h0, rgmii_rxd;
	logic [1:0] speed;
	logic rgmii_rx_ctl, mdio_i, mdio_in_data, mdc, mdio_o, mdio_t, gmii_tx_en, gmii_tx_er;
	logic fc_busy, tx_reset, rgmii_txc, link, duplex;
	int n_mismatch = 0, n_tests = 0;
	always #10 sys_clk = ~sys_clk;
	mac_tx_flow_ctrl i_mac_tx_flow_ctrl (.sys_clk(sys_clk), .rstn(rstn),
		.tx_config_vector(cfg), .client_busy(client_busy), .pause_req(pause_req),
		.pause_quanta(pause_quanta), .priority_flow_valid_n(pfv), .rgmii_rxd(rgmii_rxd),
		.rgmii_rx_ctl(rgmii_rx_ctl), .mdc_div(mdc_div), .mdio_enable(mdio_enable),
		.mdio_out_data(mdio_out_data), .mdio_out_drive(mdio_out_drive), .mdio_i(mdio_i),
		.mdio_in_data(mdio_in_data), .mdc(mdc), .mdio_o(mdio_o), .mdio_t(mdio_t),
		.gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er),
		.fc_busy(fc_busy), .tx_reset(tx_reset), .tx_max_len(tx_max_len),
		.rgmii_txc(rgmii_txc), .inband_link_status(link), .inband_clock_speed(speed),
		.inband_duplex_status(duplex));
	phy_model i_phy_model (.sys_clk(sys_clk), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
		.mdio_o(mdio_o), .mdio_t(mdio_t), .phy_drive(phy_drive), .phy_bit(phy_bit),
		.status(status), .rx_busy(rx_busy), .mdio_i(mdio_i), .rgmii_rxd(rgmii_rxd),
		.rgmii_rx_ctl(rgmii_rx_ctl));
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : tick
	task close_out;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task chk1(input logic got, input logic exp, input string m);
		chk({15'h0000, got}, {15'h0000, exp}, m);
	endtask : chk1
	function automatic logic [15:0] fw(input int k);
		return {i_phy_model.fr[k], i_phy_model.fr[k + 1]};
	endfunction : fw
	// frame check sequence over the captured bytes from destination to pad
	function automatic logic [31:0] fcs_exp();
		logic [31:0] r;
		r = `CRC_INIT;
		for (int k = `IDX_DA; k < `IDX_FCS; k++)
			for (int b = 0; b < 8; b++)
				r = (r[0] ^ i_phy_model.fr[k][b]) ? (r >> 1) ^ `CRC_POLY : r >> 1;
		return ~r;
	endfunction : fcs_exp
	task wait_frame;
		int f;
		f = i_phy_model.frames;
		for (int k = 0; k < 400 && i_phy_model.frames == f; k++) tick(1);
		if (i_phy_model.frames == f) begin
			n_mismatch++;
			$display("FAIL %0t no frame", $time);
			close_out();
		end
	endtask : wait_frame
	task chk_head(input logic [15:0] op);
		logic [47:0] sa;
		logic [47:0] da;
		logic [31:0] c;
		sa = cfg[`SA_LO+:48];
		da = `CTRL_DA;
		c = fcs_exp();
		for (int k = 0; k < 6; k += 2) chk(fw(k), 16'h5555, "preamble");
		chk(fw(6), 16'h55D5, "sfd");
		for (int k = 0; k < 6; k += 2) begin
			chk(fw(8 + k), {da[8*k+:8], da[8*k+8+:8]}, "dest");
			chk(fw(14 + k), {sa[8*k+:8], sa[8*k+8+:8]}, "source");
		end
		chk(fw(20), `ETHTYPE, "type");
		chk(fw(22), op, "opcode");
		chk(fw(68), {c[7:0], c[15:8]}, "fcs low");
		chk(fw(70), {c[23:16], c[31:24]}, "fcs high");
		chk(16'(i_phy_model.len), 16'h0048, "length");
	endtask : chk_head
	initial begin
		logic [15:0] q, m;
		int f;
		void'($urandom(7));
		tick(4);
		rstn = 1'b1;
		chk(tx_max_len, `LEGAL_LEN, "reset len");
		chk1(mdio_t, 1'b1, "reset mdio_t");
		for (int i = 0; i < 3; i++) begin
			cfg = '0;
			cfg[`TX_ON] = 1'b1;
			cfg[`FC_EN] = 1'b1;
			cfg[`SA_LO+:48] = 48'({$urandom(), $urandom()});
			pause_quanta = 16'($urandom());
			tick(4);
			pause_req = 1'b1;
			tick(1);
			pause_req = 1'b0;
			tick(2);
			chk1(fc_busy & gmii_tx_en & ~gmii_tx_er, 1'b1, "frame running");
			wait_frame();
			chk_head(`OP_PAUSE);
			chk(fw(24), pause_quanta, "quanta");
		end
		cfg[`FC_EN] = 1'b0;
		tick(4);
		f = i_phy_model.frames;
		pause_req = 1'b1;
		tick(1);
		pause_req = 1'b0;
		tick(150);
		chk(16'(i_phy_model.frames - f), 16'h0000, "pause while off");
		cfg[`FC_EN] = 1'b1;
		cfg[`AUTO_XON] = 1'b1;
		tick(4);
		pause_req = 1'b1;
		tick(3);
		pause_req = 1'b0;
		wait_frame();
		chk(fw(24), pause_quanta, "pause before xon");
		wait_frame();
		chk_head(`OP_PAUSE);
		chk(fw(24), 16'h0000, "xon quanta");
		pause_req = 1'b1;
		tick(1);
		pause_req = 1'b0;
		wait_frame();
		f = i_phy_model.frames;
		tick(150);
		chk(16'(i_phy_model.frames - f), 16'h0000, "xon after one cycle");
		for (int j = 0; j < 2; j++) begin
			cfg = '0;
			cfg[`TX_ON] = 1'b1;
			cfg[`SPEED_LO+:2] = 2'h2;
			// never both flow control enables
			if (j == 0) cfg[`FC_EN] = 1'b1;
			else cfg[`PFC_ON] = 1'b1;
			cfg[`LEG_REF_LO+:16] = 16'h0002;
			cfg[`PRIO_EN_LO+7] = 1'b1;
			cfg[`PRIO_REF_LO+7*`PRIO_STEP+:16] = 16'h0002;
			tick(4);
			pause_req = (j == 0);
			pfv = (j == 1) ? 8'h80 : 8'h00;
			wait_frame();
			wait_frame();
			chk(fw(22), (j == 0) ? `OP_PAUSE : `OP_PFC, "refresh kind");
			pause_req = 1'b0;
			pfv = 8'h00;
			tick(200);
		end
		for (int i = 0; i < 4; i++) begin
			cfg = '0;
			cfg[`TX_ON] = 1'b1;
			cfg[`PFC_ON] = 1'b1;
			cfg[`PRIO_EN_LO+:8] = (i == 0) ? 8'h01 : 8'($urandom()) | 8'h01;
			for (int n = 0; n < 8; n++) cfg[`PRIO_QNT_LO+32*n+:16] = 16'($urandom());
			tick(4);
			pfv = (i == 0) ? 8'hFF : 8'($urandom()) | 8'h01;
			m = {8'h00, pfv & cfg[`PRIO_EN_LO+:8]};
			tick(1);
			pfv = 8'h00;
			wait_frame();
			chk_head(`OP_PFC);
			chk(fw(24), m, "class mask");
			for (int n = 0; n < 8; n++) begin
				q = m[n] ? cfg[`PRIO_QNT_LO+32*n+:16] : 16'h0000;
				chk(fw(26 + 2 * n), q, "class quanta");
			end
		end
		for (int k = 0; k < 4; k++) begin
			cfg = '0;
			q = 16'h05EE + 16'($urandom() % 4000);
			cfg[`MAXLEN_LO+:16] = q;
			cfg[`VLAN_EN] = (k == 1);
			cfg[`MAX_EN] = (k >= 2);
			cfg[`JUMBO_EN] = (k == 3);
			tick(4);
			m = (k == 0) ? `LEGAL_LEN : (k == 1) ? `VLAN_LEN : (k == 2) ? q : `NO_LIMIT;
			chk(tx_max_len, m, "max len");
		end
		client_busy = 1'b1;
		cfg[`MAX_EN] = 1'b0;
		cfg[`JUMBO_EN] = 1'b0;
		cfg[`TX_RST] = 1'b1;
		tick(6);
		chk(tx_max_len, `NO_LIMIT, "held in frame");
		chk1(tx_reset, 1'b1, "reset at once");
		client_busy = 1'b0;
		tick(3);
		chk(tx_max_len, `LEGAL_LEN, "after frame");
		cfg[`TX_RST] = 1'b0;
		for (int i = 0; i < 4; i++) begin
			mdio_out_drive = i[0];
			mdio_out_data = i[1];
			tick(1);
			chk1(mdio_t, ~i[0], "mdio enable");
			if (i[0]) chk1(mdio_o, i[1], "mdio out");
			tick(4);
			chk1(mdio_in_data, i[0] ? i[1] : 1'b1, "mdio pin");
		end
		mdio_out_drive = 1'b0;
		phy_drive = 1'b1;
		tick(5);
		chk1(mdio_in_data, 1'b0, "phy drives low");
		phy_drive = 1'b0;
		tick(5);
		chk1(mdio_in_data, 1'b1, "released high");
		mdc_div = 8'($urandom() % 8);
		mdio_enable = 1'b1;
		tick(20);
		f = 0;
		q[0] = mdc;
		repeat (8 * (mdc_div + 1)) begin
			tick(1);
			if (mdc !== q[0]) f++;
			q[0] = mdc;
		end
		chk(16'(f), 16'h0008, "mdc toggles");
		for (int i = 0; i < 3; i++) begin
			status = 4'($urandom());
			tick(4);
			chk({12'h000, duplex, speed, link}, {12'h000, status}, "in-band");
			// status seen during a received frame must not be taken
			rx_busy = 1'b1;
			m[3:0] = status;
			status = ~status;
			tick(4);
			chk({12'h000, duplex, speed, link}, {12'h000, m[3:0]}, "in-band held");
			rx_busy = 1'b0;
			q[0] = rgmii_txc;
			tick(1);
			chk1(rgmii_txc, ~q[0], "tx clock");
		end
		// reset again in mid-run
		rstn = 1'b0;
		tick(2);
		chk({12'h000, duplex, speed, link}, 16'h0000, "in-band reset");
		chk1(mdc | rgmii_txc | gmii_tx_en | fc_busy | tx_reset, 1'b0, "outputs reset");
		chk1(mdio_in_data & mdio_t, 1'b1, "mdio reset");
		rstn = 1'b1;
		tick(2);
		chk(tx_max_len, `LEGAL_LEN, "len after reset");
		close_out();
	end
endmodule : testbench
